// file: rtl/sbap_consts.svh
// Constants for the line error-rate alarm and protection switch block.
// Assumes inclusion by bare name from files under rtl/.
`ifndef SBAP_CONSTS_SVH
`define SBAP_CONSTS_SVH

// Register offsets, one word each.
`define SBAP_OFF_CTRL      4'h0
`define SBAP_OFF_DEGRADE   4'h1
`define SBAP_OFF_FAILURE   4'h2
`define SBAP_OFF_RESTORE   4'h3
`define SBAP_OFF_COMMAND   4'h4
`define SBAP_OFF_STATUS    4'h5

// Control field positions.
`define SBAP_CTRL_SCRAMBLE 0
`define SBAP_CTRL_ENABLE   1
`define SBAP_CTRL_REVERT   2
`define SBAP_CTRL_LOCKOUT  3
`define SBAP_CTRL_ROLE     4
`define SBAP_CTRL_BIDIR    5

// Command field positions.
`define SBAP_CMD_FORCED    0
`define SBAP_CMD_MANUAL    1
`define SBAP_CMD_CLEAR     2

// Reset values and legal ranges.
`define SBAP_CTRL_RESET    8'h05
`define SBAP_DEG_RESET     4'h6
`define SBAP_DEG_MIN       4'h5
`define SBAP_DEG_MAX       4'h9
`define SBAP_FAIL_RESET    4'h3
`define SBAP_FAIL_MIN      4'h3
`define SBAP_FAIL_MAX      4'h5
`define SBAP_WTR_RESET     4'h5
`define SBAP_WTR_MIN       4'h5
`define SBAP_WTR_MAX       4'hC

// Timing.
`define SBAP_CLK_HZ        10000000
`define SBAP_MINUTE_S      60
`define SBAP_MINUTE_CYC    (`SBAP_CLK_HZ * `SBAP_MINUTE_S)

`endif

// file: rtl/sbap_pkg.sv
// Types for the line error-rate alarm and protection switch block.
// Assumes the constants header is compiled alongside.
package sbap_pkg;

  // Protection switch states.
  typedef enum logic [1:0] {
    SBAP_ON_WORKING,
    SBAP_ON_PROTECT,
    SBAP_WAIT_RESTORE
  } sbap_sw_t;

  // Why traffic sits on the protecting port.
  typedef enum logic [1:0] {
    SBAP_CAUSE_NONE,
    SBAP_CAUSE_SIGNAL,
    SBAP_CAUSE_FORCED,
    SBAP_CAUSE_MANUAL
  } sbap_cause_t;

endpackage : sbap_pkg

// file: rtl/sbap_minute_tick.sv
// One-cycle pulse once per minute of the system clock.
// Assumes a 10 MHz clock; the period is a parameter for short simulations.
`timescale 1ns/1ns
`include "sbap_consts.svh"
module sbap_minute_tick #(
  parameter int unsigned MINUTE_CYCLES = `SBAP_MINUTE_CYC
) (
  // Clock and reset.
  input  wire logic SYS_CLK,
  input  wire logic SYS_RST,
  // Counter control and pulse.
  input  wire logic run,
  output logic      tick
);

  typedef struct packed {
    logic [31:0] count;
    logic        tick;
  } sbap_tick_state_t;

  sbap_tick_state_t cur;
  sbap_tick_state_t next_cur;

  // Counts while run is high and restarts whenever run drops.
  always_comb
  begin
    next_cur      = cur;
    next_cur.tick = 1'b0;
    if (!run)
    begin
      next_cur.count = 32'h0;
    end
    else if (cur.count >= MINUTE_CYCLES - 1)
    begin
      next_cur.count = 32'h0;
      next_cur.tick  = 1'b1;
    end
    else
    begin
      next_cur.count = cur.count + 32'h1;
    end
  end

  // State register.
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign tick = cur.tick;

endmodule : sbap_minute_tick

// file: rtl/sbap_port_ctrl.sv
// Per-port error-rate alarms and 1+1 protection switching.
// Assumes a measured error-rate exponent from the framer, valid when BER_VALID is high.
// How it works
// [R1] Degrade exponent writes from 5 to 9 are taken; others are ignored.
// [R2] Degrade exponent resets to 6, one error per million bits.
// [R3] Failure exponent writes from 3 to 5 are taken; others are ignored.
// [R4] Failure exponent resets to 3, one error per thousand bits.
// [R5] Rate at or above degrade threshold raises degrade alarm and condition.
// [R6] Rate at or above failure threshold raises failure alarm and condition.
// [R7] Degrade alarm is always high whenever failure alarm is high.
// [R8] Working port degrade moves traffic to protecting port if configured.
// [R9] Working port failure moves traffic to protecting port if configured.
// [R10] Restore wait is 5 to 12 whole minutes, reset value 5.
// [R11] Traffic returns to working only when the restore wait expires, on a clear command while on protect (not during the wait), or when protection is disabled.
// [R12] One enable switches transmit scrambling and receive descrambling together.
// [R13] Status register shows level, role, direction and switch state.
// [R14] Nonrevertive mode keeps traffic on protecting port after recovery.
// [R15] Lockout on protecting port blocks switching to it on alarms.
// [R16] Alarms drop below threshold; in revertive mode the drop starts the restore wait.
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ns
`include "sbap_consts.svh"
module sbap_port_ctrl #(
  parameter int unsigned MINUTE_CYCLES = `SBAP_MINUTE_CYC
) (
  // Clock and reset.
  input  wire logic       SYS_CLK,
  input  wire logic       SYS_RST,
  // Register port.
  input  wire logic [3:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  // Measured error rate: exponent n of ten to the minus n, valid when high.
  input  wire logic [3:0] BER_EXPONENT,
  input  wire logic       BER_VALID,
  // Alarms and switch outputs.
  output logic            DEGRADE_ALARM,
  output logic            FAILURE_ALARM,
  output logic            USE_PROTECT,
  output logic            SCRAMBLE_TX_EN,
  output logic            DESCRAMBLE_RX_EN
);

  typedef struct packed {
    logic [7:0]           ctrl;
    logic [3:0]           degrade_ber_exponent;
    logic [3:0]           failure_ber_exponent;
    logic [3:0]           restore_minutes;
    logic [3:0]           restore_wait_timer;
    sbap_pkg::sbap_sw_t   sw;
    sbap_pkg::sbap_cause_t cause;
    logic                 degrade;
    logic                 failure;
    logic [7:0]           rdata;
  } sbap_state_t;

  sbap_state_t cur;
  sbap_state_t next_cur;
  logic        minute_tick;
  logic        deg_hit;
  logic        fail_hit;
  logic        signal_bad;
  logic        lockout;

  // Minute pulses run only while the restore wait is in progress.
  sbap_minute_tick #(
    .MINUTE_CYCLES (MINUTE_CYCLES)
  ) u_tick (
    .SYS_CLK (SYS_CLK),
    .SYS_RST (SYS_RST),
    .run     (cur.sw == sbap_pkg::SBAP_WAIT_RESTORE),
    .tick    (minute_tick)
  );

  // Threshold compares: a smaller exponent means a higher error rate.
  always_comb
  begin
    // [R5] Degrade threshold reached.
    deg_hit = BER_VALID && (BER_EXPONENT <= cur.degrade_ber_exponent);
    // [R6] Failure threshold reached.
    fail_hit = BER_VALID && (BER_EXPONENT <= cur.failure_ber_exponent);
    signal_bad = cur.degrade || cur.failure;
    lockout = cur.ctrl[`SBAP_CTRL_LOCKOUT];
  end

  // Next-state logic: registers, alarms, switch machine and read data.
  always_comb
  begin
    next_cur       = cur;
    next_cur.rdata = 8'h00;

    // [R16] Alarms follow the rate and drop once it falls below.
    next_cur.failure = fail_hit;
    // [R7] Failure always implies degrade.
    next_cur.degrade = deg_hit || fail_hit;

    // Register writes.
    if (REG_WR)
    begin
      unique case (REG_ADDR)
        `SBAP_OFF_CTRL:
        begin
          next_cur.ctrl = REG_WDATA;
        end
        `SBAP_OFF_DEGRADE:
        begin
          // [R1] Degrade range check.
          if (REG_WDATA >= {4'h0, `SBAP_DEG_MIN} && REG_WDATA <= {4'h0, `SBAP_DEG_MAX})
          begin
            next_cur.degrade_ber_exponent = REG_WDATA[3:0];
          end
        end
        `SBAP_OFF_FAILURE:
        begin
          // [R3] Failure range check.
          if (REG_WDATA >= {4'h0, `SBAP_FAIL_MIN} && REG_WDATA <= {4'h0, `SBAP_FAIL_MAX})
          begin
            next_cur.failure_ber_exponent = REG_WDATA[3:0];
          end
        end
        `SBAP_OFF_RESTORE:
        begin
          // [R10] Restore wait range check.
          if (REG_WDATA >= {4'h0, `SBAP_WTR_MIN} && REG_WDATA <= {4'h0, `SBAP_WTR_MAX})
          begin
            next_cur.restore_minutes = REG_WDATA[3:0];
          end
        end
        default:
        begin
        end
      endcase
    end

    // Protection switch machine, active only when protection is enabled.
    if (!cur.ctrl[`SBAP_CTRL_ENABLE])
    begin
      next_cur.sw    = sbap_pkg::SBAP_ON_WORKING;
      next_cur.cause = sbap_pkg::SBAP_CAUSE_NONE;
    end
    else
    begin
      unique case (cur.sw)
        sbap_pkg::SBAP_ON_WORKING:
        begin
          // [R15] Lockout blocks every move to the protecting port.
          if (!lockout)
          begin
            // [R8] [R9] Degrade or failure moves traffic.
            if (signal_bad)
            begin
              next_cur.sw    = sbap_pkg::SBAP_ON_PROTECT;
              next_cur.cause = sbap_pkg::SBAP_CAUSE_SIGNAL;
            end
            else if (REG_WR && REG_ADDR == `SBAP_OFF_COMMAND && REG_WDATA[`SBAP_CMD_FORCED])
            begin
              next_cur.sw    = sbap_pkg::SBAP_ON_PROTECT;
              next_cur.cause = sbap_pkg::SBAP_CAUSE_FORCED;
            end
            else if (REG_WR && REG_ADDR == `SBAP_OFF_COMMAND && REG_WDATA[`SBAP_CMD_MANUAL])
            begin
              next_cur.sw    = sbap_pkg::SBAP_ON_PROTECT;
              next_cur.cause = sbap_pkg::SBAP_CAUSE_MANUAL;
            end
          end
        end
        sbap_pkg::SBAP_ON_PROTECT:
        begin
          if (REG_WR && REG_ADDR == `SBAP_OFF_COMMAND && REG_WDATA[`SBAP_CMD_CLEAR])
          begin
            next_cur.sw    = sbap_pkg::SBAP_ON_WORKING;
            next_cur.cause = sbap_pkg::SBAP_CAUSE_NONE;
          end
          // [R14] Nonrevertive holds traffic on the protecting port.
          else if (cur.cause == sbap_pkg::SBAP_CAUSE_SIGNAL && !signal_bad && cur.ctrl[`SBAP_CTRL_REVERT])
          begin
            // [R16] Alarm drop starts the restore wait.
            next_cur.sw                 = sbap_pkg::SBAP_WAIT_RESTORE;
            next_cur.restore_wait_timer = cur.restore_minutes;
          end
        end
        sbap_pkg::SBAP_WAIT_RESTORE:
        begin
          if (signal_bad)
          begin
            next_cur.sw = sbap_pkg::SBAP_ON_PROTECT;
          end
          else if (minute_tick)
          begin
            // [R11] Return only when the last minute expires.
            if (cur.restore_wait_timer <= 4'h1)
            begin
              next_cur.sw                 = sbap_pkg::SBAP_ON_WORKING;
              next_cur.cause              = sbap_pkg::SBAP_CAUSE_NONE;
              next_cur.restore_wait_timer = 4'h0;
            end
            else
            begin
              next_cur.restore_wait_timer = cur.restore_wait_timer - 4'h1;
            end
          end
        end
        default:
        begin
          next_cur.sw = sbap_pkg::SBAP_ON_WORKING;
        end
      endcase
    end

    // Read data, valid in the cycle after the strobe.
    if (REG_RD)
    begin
      unique case (REG_ADDR)
        `SBAP_OFF_CTRL:
        begin
          next_cur.rdata = cur.ctrl;
        end
        `SBAP_OFF_DEGRADE:
        begin
          next_cur.rdata = {4'h0, cur.degrade_ber_exponent};
        end
        `SBAP_OFF_FAILURE:
        begin
          next_cur.rdata = {4'h0, cur.failure_ber_exponent};
        end
        `SBAP_OFF_RESTORE:
        begin
          next_cur.rdata = {cur.restore_wait_timer, cur.restore_minutes};
        end
        `SBAP_OFF_STATUS:
        begin
          // [R13] Protection status view.
          next_cur.rdata = {cur.failure, cur.degrade, cur.ctrl[`SBAP_CTRL_BIDIR],
                            cur.ctrl[`SBAP_CTRL_ROLE], cur.ctrl[`SBAP_CTRL_ENABLE],
                            cur.cause == sbap_pkg::SBAP_CAUSE_FORCED, cur.sw};
        end
        default:
        begin
          next_cur.rdata = 8'h00;
        end
      endcase
    end
  end

  // State register with documented reset values.
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      cur.ctrl                 <= `SBAP_CTRL_RESET;
      // [R2] Degrade default.
      cur.degrade_ber_exponent <= `SBAP_DEG_RESET;
      // [R4] Failure default.
      cur.failure_ber_exponent <= `SBAP_FAIL_RESET;
      // [R10] Restore wait default.
      cur.restore_minutes      <= `SBAP_WTR_RESET;
      cur.restore_wait_timer   <= 4'h0;
      cur.sw                   <= sbap_pkg::SBAP_ON_WORKING;
      cur.cause                <= sbap_pkg::SBAP_CAUSE_NONE;
      cur.degrade              <= 1'b0;
      cur.failure              <= 1'b0;
      cur.rdata                <= 8'h00;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // Outputs straight from state.
  assign REG_RDATA     = cur.rdata;
  assign DEGRADE_ALARM = cur.degrade;
  assign FAILURE_ALARM = cur.failure;
  assign USE_PROTECT   = (cur.sw != sbap_pkg::SBAP_ON_WORKING);
  // [R12] One bit drives both directions.
  assign SCRAMBLE_TX_EN   = cur.ctrl[`SBAP_CTRL_SCRAMBLE];
  assign DESCRAMBLE_RX_EN = cur.ctrl[`SBAP_CTRL_SCRAMBLE];

endmodule : sbap_port_ctrl

// file: test/sbap_assertions.sv
// Checker for the port alarm and protection block.
// Assumes it is bound onto sbap_port_ctrl and sees only its ports.
`timescale 1ns/1ns
module sbap_checker #(
  parameter int unsigned MINUTE_CYCLES = 20
) (
  // Clock and reset.
  input wire logic       SYS_CLK,
  input wire logic       SYS_RST,
  // Watched ports.
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic [3:0] BER_EXPONENT,
  input wire logic       BER_VALID,
  input wire logic       DEGRADE_ALARM,
  input wire logic       FAILURE_ALARM,
  input wire logic       USE_PROTECT,
  input wire logic       SCRAMBLE_TX_EN,
  input wire logic       DESCRAMBLE_RX_EN
);
  int unsigned quiet;
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (SYS_RST);
  // Counts cycles with no alarm and no register write.
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
    if (SYS_RST)
      quiet <= 0;
    else if (DEGRADE_ALARM || REG_WR)
      quiet <= 0;
    else
      quiet <= quiet + 1;
  stage_order_a: assert property (FAILURE_ALARM |-> DEGRADE_ALARM)
    else $error("failure alarm without degrade alarm");
  deg_raise_a: assert property (BER_VALID && BER_EXPONENT <= 4'h5 |=> DEGRADE_ALARM)
    else $error("degrade alarm missing");
  fail_raise_a: assert property (BER_VALID && BER_EXPONENT <= 4'h3 |=> FAILURE_ALARM)
    else $error("failure alarm missing");
  fail_low_a: assert property (BER_VALID && BER_EXPONENT > 4'h5 |=> !FAILURE_ALARM)
    else $error("failure alarm on a clean rate");
  deg_low_a: assert property (BER_VALID && BER_EXPONENT > 4'h9 |=> !DEGRADE_ALARM)
    else $error("degrade alarm on a clean rate");
  alarm_drop_a: assert property (!BER_VALID |=> !DEGRADE_ALARM && !FAILURE_ALARM)
    else $error("alarm held without a rate");
  scram_pair_a: assert property (SCRAMBLE_TX_EN == DESCRAMBLE_RX_EN)
    else $error("scramble enables differ");
  early_back_a: assert property ($fell(USE_PROTECT) && quiet > 3 |-> quiet >= 4 * MINUTE_CYCLES)
    else $error("switched back before the restore wait");
  cover property ($rose(USE_PROTECT));
  cover property ($fell(USE_PROTECT));
  cover property ($rose(FAILURE_ALARM));
endmodule : sbap_checker
bind sbap_port_ctrl sbap_checker #(.MINUTE_CYCLES(MINUTE_CYCLES)) chk (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .BER_EXPONENT(BER_EXPONENT), .BER_VALID(BER_VALID), .DEGRADE_ALARM(DEGRADE_ALARM),
  .FAILURE_ALARM(FAILURE_ALARM), .USE_PROTECT(USE_PROTECT), .SCRAMBLE_TX_EN(SCRAMBLE_TX_EN),
  .DESCRAMBLE_RX_EN(DESCRAMBLE_RX_EN));

// file: test/sbap_far_end.sv
// Far-end line model presenting the measured error-rate exponent.
// Assumes the bench sets the wanted exponent and validity.
`timescale 1ns/1ns
module sbap_far_end (
  // Clock.
  input  wire logic       SYS_CLK,
  // Wanted line quality.
  input  wire logic [3:0] want_exp,
  input  wire logic       want_on,
  // Measured rate toward the block.
  output logic      [3:0] BER_EXPONENT,
  output logic            BER_VALID
);
  initial BER_EXPONENT = 4'h0;
  initial BER_VALID = 1'b0;
  // Registers the wanted rate; a meaningless exponent keeps changing.
  always @(posedge SYS_CLK)
  begin
    BER_VALID    <= want_on;
    BER_EXPONENT <= want_on ? want_exp : BER_EXPONENT + 4'h1;
  end
endmodule : sbap_far_end

// file: test/sbap_port_ctrl_test.sv
// Bench for the port alarm and protection block.
// Assumes a 10 MHz clock and twenty-cycle minutes.
`timescale 1ns/1ns
module sbap_port_ctrl_test;
  localparam int unsigned MC = 20;
  logic       SYS_CLK = 1'b0;
  logic       SYS_RST = 1'b1;
  logic [3:0] REG_ADDR = 4'h0;
  logic [7:0] REG_WDATA = 8'h00;
  logic       REG_WR = 1'b0;
  logic       REG_RD = 1'b0;
  logic [3:0] want_exp = 4'hA;
  logic       want_on = 1'b0;
  wire  [7:0] REG_RDATA;
  wire  [3:0] BER_EXPONENT;
  wire        BER_VALID, DEGRADE_ALARM, FAILURE_ALARM, USE_PROTECT, SCRAMBLE_TX_EN, DESCRAMBLE_RX_EN;
  wire  [7:0] outs = {3'h0, DESCRAMBLE_RX_EN, SCRAMBLE_TX_EN, USE_PROTECT, FAILURE_ALARM, DEGRADE_ALARM};
  int         err_total = 0;
  int         n_compared = 0;
  int         cyc = 0;
  logic [3:0] ta [13] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2, 4'h2, 4'h3, 4'h3, 4'h3, 4'h3};
  logic [7:0] td [13] = '{8'h04, 8'h0A, 8'h09, 8'h05, 8'h06, 8'h02, 8'h06, 8'h05, 8'h03, 8'h04, 8'h0D, 8'h0C, 8'h05};
  logic [7:0] te [13] = '{8'h06, 8'h06, 8'h09, 8'h05, 8'h06, 8'h03, 8'h03, 8'h05, 8'h03, 8'h05, 8'h05, 8'h0C, 8'h05};
  // Clock of 100 ns.
  always #50 SYS_CLK = ~SYS_CLK;
  sbap_port_ctrl #(.MINUTE_CYCLES(MC)) dut (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .BER_EXPONENT(BER_EXPONENT), .BER_VALID(BER_VALID), .DEGRADE_ALARM(DEGRADE_ALARM),
    .FAILURE_ALARM(FAILURE_ALARM), .USE_PROTECT(USE_PROTECT), .SCRAMBLE_TX_EN(SCRAMBLE_TX_EN),
    .DESCRAMBLE_RX_EN(DESCRAMBLE_RX_EN));
  sbap_far_end far (.SYS_CLK(SYS_CLK), .want_exp(want_exp), .want_on(want_on),
    .BER_EXPONENT(BER_EXPONENT), .BER_VALID(BER_VALID));
  // Prints the verdict and ends the run.
  task automatic tally_and_finish;
    if (err_total == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  // Compares one value and reports a difference.
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    n_compared++;
    if (got !== ex)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // One-cycle register write.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge SYS_CLK);
    REG_WR    <= 1'b0;
  endtask : wr
  // One-cycle register read, data checked in the following cycle.
  task automatic rdc(input logic [3:0] a, input logic [7:0] ex, input string nm, input logic [7:0] mk = 8'hFF);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge SYS_CLK);
    REG_RD   <= 1'b0;
    #50 chk(nm, ex, REG_RDATA & mk);
  endtask : rdc
  // Sets the far-end rate and lets alarms and switching settle.
  task automatic line(input logic [3:0] n, input logic on);
    @(posedge SYS_CLK);
    want_exp <= n;
    want_on  <= on;
    repeat (4) @(posedge SYS_CLK);
    #50;
  endtask : line
  // Main sequence.
  initial
  begin
    repeat (16) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    #50 chk("outs", 8'h18, outs);
    rdc(4'h0, 8'h05, "ctrl");
    rdc(4'h1, 8'h06, "degrade exp");
    rdc(4'h2, 8'h03, "failure exp");
    rdc(4'h3, 8'h05, "restore", 8'h0F);
    rdc(4'hF, 8'h00, "unmapped");
    for (int i = 0; i < 13; i++)
    begin
      wr(ta[i], td[i]);
      rdc(ta[i], te[i], "range", 8'h0F);
    end
    // Control resets with protection off; turn it on, nonrevertive, scrambling kept.
    wr(4'h0, 8'h03);
    line(4'hA, 1'b1);
    chk("clean", 8'h18, outs);
    line(4'h6, 1'b1);
    chk("degrade", 8'h1D, outs);
    line(4'h3, 1'b1);
    chk("failure", 8'h1F, outs);
    line(4'h0, 1'b0);
    repeat (6 * MC) @(posedge SYS_CLK);
    chk("hold", 8'h1C, outs);
    rdc(4'h5, 8'h09, "status");
    wr(4'h4, 8'h04);
    rdc(4'h5, 8'h08, "status");
    wr(4'h0, 8'h07);
    line(4'h3, 1'b1);
    chk("switch", 8'h1F, outs);
    line(4'hA, 1'b1);
    repeat (3 * MC) @(posedge SYS_CLK);
    rdc(4'h5, 8'h0A, "waiting");
    for (int i = 0; i < 8 * MC && USE_PROTECT === 1'b1; i++)
      @(posedge SYS_CLK);
    #50;
    chk("restored", 8'h18, outs);
    wr(4'h0, 8'h0E);
    line(4'h3, 1'b1);
    chk("lockout", 8'h03, outs);
    line(4'hA, 1'b1);
    wr(4'h0, 8'h36);
    rdc(4'h5, 8'h38, "roles");
    tally_and_finish();
  end
  // Cuts a hung run short.
  always @(posedge SYS_CLK)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      tally_and_finish();
    end
  end
endmodule : sbap_port_ctrl_test
